// ---- lrx_defines.svh ----
`ifndef LRX_DEFINES_SVH
`define LRX_DEFINES_SVH

// register indexes; byte address is four times the index
`define LRX_IDX_PATH_CTRL 8'h0A
`define LRX_IDX_MISC_CTRL 8'h0B
`define LRX_IDX_I_LVL_LO 8'h0C
`define LRX_IDX_I_LVL_HI 8'h0D
`define LRX_IDX_Q_LVL_LO 8'h0E
`define LRX_IDX_Q_LVL_HI 8'h0F
`define LRX_IDX_OBS_LO 8'h10
`define LRX_IDX_OBS_HI 8'h18
`define LRX_IDX_STATUS 8'h19

// input path control fields
`define LRX_BIT_EDGE 0
`define LRX_BIT_LAYOUT 1
`define LRX_BIT_SWAP 2
`define LRX_POS_DE_SEL 4

// misc control fields
`define LRX_POS_MODE 0
`define LRX_POS_Q_SEL 2
`define LRX_POS_I_SEL 4
`define LRX_BIT_SOFT_RST 7

`define LRX_RST_BYTE 8'h00
`define LRX_RST_OBS_HI 2'h0

// rate ratios of the crossing unit
`define LRX_RATIO_X2 4'h2
`define LRX_RATIO_X4 4'h4
`define LRX_RATIO_X8 4'h8

`endif

// ---- lrx_pkg.sv ----
package lrx_pkg;
  typedef enum logic [1:0] {LRX_PH_I = 2'b01, LRX_PH_Q = 2'b10} lrx_phase_t;
  typedef enum logic [1:0] {LRX_SRC_PASS = 2'h0, LRX_SRC_GATED = 2'h1, LRX_SRC_FORCE = 2'h2,
    LRX_SRC_FORCE2 = 2'h3} lrx_src_t;
  typedef enum logic [1:0] {LRX_MODE_X2 = 2'h0, LRX_MODE_X4 = 2'h1, LRX_MODE_X8 = 2'h2,
    LRX_MODE_NONE = 2'h3} lrx_mode_t;
endpackage

// ---- lrx_capture.sv ----
`timescale 1ns/10ps
`default_nettype none
module lrx_capture #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic input_port_clock,
  input wire logic [WIDTH-1:0] data_a_pin,
  input wire logic [WIDTH-1:0] data_b_pin,
  input wire logic align_a_pin,
  input wire logic align_b_pin,
  input wire logic capture_edge_select,
  input wire logic lane_pair_exchange,
  input wire logic iq_layout_select,
  output logic port_clk_sync,
  output logic align_a,
  output logic align_b,
  output logic [WIDTH-1:0] rx_a,
  output logic [WIDTH-1:0] rx_b,
  output logic [WIDTH-1:0] word_i,
  output logic [WIDTH-1:0] word_q,
  output logic word_valid
);
  // ----------------------------------------
  // two-flop synchronisers
  // ----------------------------------------
  logic [2*WIDTH+2:0] meta;
  logic [2*WIDTH+2:0] sync;
  logic clk_d;
  logic edge_hit;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync <= '0;
      clk_d <= 1'b0;
    end
    else
    begin
      meta <= {input_port_clock, align_a_pin, align_b_pin, data_a_pin, data_b_pin};
      sync <= meta;
      clk_d <= sync[2*WIDTH+2];
    end
  end
  assign port_clk_sync = sync[2*WIDTH+2];
  assign align_a = sync[2*WIDTH+1];
  assign align_b = sync[2*WIDTH];
  // rising or falling edge of the link clock as chosen
  assign edge_hit = capture_edge_select ? (port_clk_sync & ~clk_d) : (~port_clk_sync & clk_d); // [RQ3]

  // ----------------------------------------
  // capture, lane exchange and i/q demux
  // ----------------------------------------
  lrx_pkg::lrx_phase_t phase;
  lrx_pkg::lrx_phase_t next_phase;
  logic [WIDTH-1:0] next_rx_a;
  logic [WIDTH-1:0] next_rx_b;
  logic [WIDTH-1:0] next_word_i;
  logic [WIDTH-1:0] next_word_q;
  logic next_word_valid;
  logic [WIDTH-1:0] lane_a;
  logic [WIDTH-1:0] lane_b;
  always_comb
  begin
    lane_a = lane_pair_exchange ? sync[WIDTH-1:0] : sync[2*WIDTH-1:WIDTH]; // [RQ1]
    lane_b = lane_pair_exchange ? sync[2*WIDTH-1:WIDTH] : sync[WIDTH-1:0]; // [RQ1]
    next_rx_a = rx_a;
    next_rx_b = rx_b;
    next_word_i = word_i;
    next_word_q = word_q;
    next_word_valid = 1'b0;
    next_phase = phase;
    if (soft_rst)
      next_phase = lrx_pkg::LRX_PH_I;
    else if (edge_hit)
    begin
      next_rx_a = lane_a;
      next_rx_b = lane_b;
      if (!iq_layout_select)
      begin
        // folded: i on lane a, q on lane b at once
        next_word_i = lane_a; // [RQ2]
        next_word_q = lane_b; // [RQ2]
        next_word_valid = 1'b1;
        next_phase = lrx_pkg::LRX_PH_I;
      end
      else
      begin
        // interleaved: i then q on successive edges of lane a
        case (phase)
          lrx_pkg::LRX_PH_I:
          begin
            next_word_i = lane_a; // [RQ2]
            next_phase = lrx_pkg::LRX_PH_Q;
          end
          lrx_pkg::LRX_PH_Q:
          begin
            next_word_q = lane_a; // [RQ2]
            next_word_valid = 1'b1;
            next_phase = lrx_pkg::LRX_PH_I;
          end
          default:
            next_phase = lrx_pkg::LRX_PH_I;
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= lrx_pkg::LRX_PH_I;
      rx_a <= '0;
      rx_b <= '0;
      word_i <= '0;
      word_q <= '0;
      word_valid <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      rx_a <= next_rx_a;
      rx_b <= next_rx_b;
      word_i <= next_word_i;
      word_q <= next_word_q;
      word_valid <= next_word_valid;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_swap_lanes;
    edge_hit && !soft_rst && lane_pair_exchange |=> rx_a == $past(sync[WIDTH-1:0]);
  endproperty
  a_swap_lanes: assert property (p_swap_lanes) else $error("lane exchange not applied"); // [RQ1]
  property p_fall_edge;
    $fell(port_clk_sync) && !capture_edge_select && !soft_rst |=> rx_b == $past(lane_b);
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge capture missed"); // [RQ3]
  sequence s_i_then_q;
    edge_hit && iq_layout_select && phase == lrx_pkg::LRX_PH_I && !soft_rst;
  endsequence
  property p_interleave;
    s_i_then_q |=> !word_valid && word_i == $past(lane_a);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved i word wrong"); // [RQ2]
endmodule
`default_nettype wire

// ---- lrx_observe_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module lrx_observe_mux (
  input wire logic [9:0] code,
  input wire logic port_clk,
  input wire logic slow_osc,
  input wire logic [15:0] rx_a,
  input wire logic [15:0] rx_b,
  input wire logic irq,
  output logic pin_value
);
  // ----------------------------------------
  // selection of the observed signal
  // ----------------------------------------
  always_comb
  begin
    pin_value = 1'b0; // [RQ16]
    if (code[9:4] == 6'h10)
      pin_value = rx_a[code[3:0]]; // [RQ10]
    else
    begin
      case (code)
        10'h000: pin_value = port_clk; // [RQ9]
        10'h001: pin_value = slow_osc; // [RQ9]
        10'h20F: pin_value = &rx_b; // [RQ11]
        10'h21F: pin_value = |rx_b; // [RQ11]
        10'h22F: pin_value = &rx_a; // [RQ12]
        10'h23F: pin_value = |rx_a; // [RQ12]
        10'h3C0: pin_value = ~irq; // [RQ13]
        10'h3C1: pin_value = irq; // [RQ13]
        10'h3FE: pin_value = 1'b1; // [RQ14]
        10'h3FF: pin_value = 1'b0; // [RQ14]
        default: pin_value = 1'b0; // [RQ16]
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- lrx_top.sv ----
// How it works
// [RQ1] lane exchange bit swaps received channel a and b paths
// [RQ2] layout bit picks folded (0) or interleaved (1) i/q demux
// [RQ3] capture on falling link clock edge at 0, rising at 1
// [RQ4] writing 1 to misc bit 7 resets the crossing unit; 0 does nothing
// [RQ5] i source: 00 pass, 01 pass when enabled else level, 1x level
// [RQ6] q source behaves the same with the q level
// [RQ7] crossing mode sets ratio x2, x4, x8; code 11 unused
// [RQ8] each 16-bit level built from low byte and next high byte
// [RQ9] observe codes 000 and 001 give port clock and slow oscillator
// [RQ10] code 01 0000 nnnn shows channel a bit nnnn
// [RQ11] codes 20F and 21F show and / or of channel b bits
// [RQ12] codes 22F and 23F show and / or of channel a bits
// [RQ13] codes 3C0 and 3C1 show interrupt low or high active
// [RQ14] code 3FE drives pin high, 3FF drives it low
// [RQ15] data enable source: 00 align a, 01 align b, 10 zero, 11 one
// [RQ16] any other observe code drives the pin low
`timescale 1ns/10ps
`default_nettype none
`include "lrx_defines.svh"
module lrx_top #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_port_clock,
  input wire logic [WIDTH-1:0] data_a_pin,
  input wire logic [WIDTH-1:0] data_b_pin,
  input wire logic align_a_pin,
  input wire logic align_b_pin,
  input wire logic slow_osc_pin,
  input wire logic irq_out,
  output logic [WIDTH-1:0] dsp_i,
  output logic [WIDTH-1:0] dsp_q,
  output logic dsp_strobe,
  output logic observe_pin0
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] input_path_control;
  logic [7:0] misc_control;
  logic [7:0] i_constant_level_low;
  logic [7:0] i_constant_level_high;
  logic [7:0] q_constant_level_low;
  logic [7:0] q_constant_level_high;
  logic [7:0] pin0_observe_select;
  logic [1:0] pin0_observe_high;
  logic crossing_soft_reset;
  logic [7:0] next_input_path_control;
  logic [7:0] next_misc_control;
  logic [7:0] next_i_lo;
  logic [7:0] next_i_hi;
  logic [7:0] next_q_lo;
  logic [7:0] next_q_hi;
  logic [7:0] next_obs_lo;
  logic [1:0] next_obs_hi;
  logic next_soft_reset;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_take;
  logic [9:0] reg_index;
  logic [31:0] rd_value;
  logic rd_hit;
  logic [15:0] i_constant_level;
  logic [15:0] q_constant_level;
  logic [9:0] pin0_observe_code;

  // word address to register index; misaligned addresses go unmapped
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
  endfunction

  assign reg_index = paddr[11:2];
  assign wr_take = psel & penable & pready & pwrite;
  assign i_constant_level = {i_constant_level_high, i_constant_level_low}; // [RQ8]
  assign q_constant_level = {q_constant_level_high, q_constant_level_low}; // [RQ8]
  assign pin0_observe_code = {pin0_observe_high, pin0_observe_select};

  logic [WIDTH-1:0] rx_a;
  logic [WIDTH-1:0] rx_b;
  logic data_enable;
  logic [3:0] rate_left;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_value = 32'h0000_0000;
    if (hit(paddr, `LRX_IDX_PATH_CTRL))
      rd_value = {24'h000000, input_path_control};
    else if (hit(paddr, `LRX_IDX_MISC_CTRL))
      rd_value = {24'h000000, misc_control};
    else if (hit(paddr, `LRX_IDX_I_LVL_LO))
      rd_value = {24'h000000, i_constant_level_low};
    else if (hit(paddr, `LRX_IDX_I_LVL_HI))
      rd_value = {24'h000000, i_constant_level_high};
    else if (hit(paddr, `LRX_IDX_Q_LVL_LO))
      rd_value = {24'h000000, q_constant_level_low};
    else if (hit(paddr, `LRX_IDX_Q_LVL_HI))
      rd_value = {24'h000000, q_constant_level_high};
    else if (hit(paddr, `LRX_IDX_OBS_LO))
      rd_value = {24'h000000, pin0_observe_select};
    else if (hit(paddr, `LRX_IDX_OBS_HI))
      rd_value = {30'h00000000, pin0_observe_high};
    else if (hit(paddr, `LRX_IDX_STATUS))
      rd_value = {10'h000, rate_left, observe_pin0, data_enable, rx_a};
    else
      rd_hit = 1'b0;
  end

  always_comb
  begin
    next_input_path_control = input_path_control;
    next_misc_control = misc_control;
    next_i_lo = i_constant_level_low;
    next_i_hi = i_constant_level_high;
    next_q_lo = q_constant_level_low;
    next_q_hi = q_constant_level_high;
    next_obs_lo = pin0_observe_select;
    next_obs_hi = pin0_observe_high;
    next_soft_reset = 1'b0;
    // zero-wait slave: ready is raised for the access phase only
    next_pready = psel & ~penable;
    next_prdata = (psel & ~penable & ~pwrite) ? rd_value : 32'h0000_0000;
    next_pslverr = psel & ~penable & ~rd_hit;
    if (wr_take)
    begin
      if (hit(paddr, `LRX_IDX_PATH_CTRL))
        next_input_path_control = pwdata[7:0];
      if (hit(paddr, `LRX_IDX_MISC_CTRL))
      begin
        // reset bit self-clears; a pulse is all the crossing unit needs
        next_misc_control = {1'b0, pwdata[6:0]};
        next_soft_reset = pwdata[`LRX_BIT_SOFT_RST]; // [RQ4]
      end
      if (hit(paddr, `LRX_IDX_I_LVL_LO))
        next_i_lo = pwdata[7:0]; // [RQ8]
      if (hit(paddr, `LRX_IDX_I_LVL_HI))
        next_i_hi = pwdata[7:0]; // [RQ8]
      if (hit(paddr, `LRX_IDX_Q_LVL_LO))
        next_q_lo = pwdata[7:0]; // [RQ8]
      if (hit(paddr, `LRX_IDX_Q_LVL_HI))
        next_q_hi = pwdata[7:0]; // [RQ8]
      if (hit(paddr, `LRX_IDX_OBS_LO))
        next_obs_lo = pwdata[7:0];
      if (hit(paddr, `LRX_IDX_OBS_HI))
        next_obs_hi = pwdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_path_control <= `LRX_RST_BYTE;
      misc_control <= `LRX_RST_BYTE;
      i_constant_level_low <= `LRX_RST_BYTE;
      i_constant_level_high <= `LRX_RST_BYTE;
      q_constant_level_low <= `LRX_RST_BYTE;
      q_constant_level_high <= `LRX_RST_BYTE;
      pin0_observe_select <= `LRX_RST_BYTE;
      pin0_observe_high <= `LRX_RST_OBS_HI;
      crossing_soft_reset <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      input_path_control <= next_input_path_control;
      misc_control <= next_misc_control;
      i_constant_level_low <= next_i_lo;
      i_constant_level_high <= next_i_hi;
      q_constant_level_low <= next_q_lo;
      q_constant_level_high <= next_q_hi;
      pin0_observe_select <= next_obs_lo;
      pin0_observe_high <= next_obs_hi;
      crossing_soft_reset <= next_soft_reset;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // receive capture
  // ----------------------------------------
  logic port_clk_sync;
  logic align_a;
  logic align_b;
  logic [WIDTH-1:0] word_i;
  logic [WIDTH-1:0] word_q;
  logic word_valid;
  lrx_capture #(.WIDTH(WIDTH)) u_capture (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .soft_rst(crossing_soft_reset),
    .input_port_clock(input_port_clock),
    .data_a_pin(data_a_pin),
    .data_b_pin(data_b_pin),
    .align_a_pin(align_a_pin),
    .align_b_pin(align_b_pin),
    .capture_edge_select(input_path_control[`LRX_BIT_EDGE]),
    .lane_pair_exchange(input_path_control[`LRX_BIT_SWAP]),
    .iq_layout_select(input_path_control[`LRX_BIT_LAYOUT]),
    .port_clk_sync(port_clk_sync),
    .align_a(align_a),
    .align_b(align_b),
    .rx_a(rx_a),
    .rx_b(rx_b),
    .word_i(word_i),
    .word_q(word_q),
    .word_valid(word_valid)
  );

  // ----------------------------------------
  // crossing unit and level substitution
  // ----------------------------------------
  logic [1:0] de_select;
  logic [1:0] i_source_select;
  logic [1:0] q_source_select;
  logic [1:0] cdi_mode;
  logic [WIDTH-1:0] cdi_i;
  logic [WIDTH-1:0] cdi_q;
  logic [WIDTH-1:0] next_cdi_i;
  logic [WIDTH-1:0] next_cdi_q;
  logic [3:0] next_rate_left;
  logic [WIDTH-1:0] next_dsp_i;
  logic [WIDTH-1:0] next_dsp_q;
  logic next_dsp_strobe;
  logic [3:0] ratio;

  assign de_select = input_path_control[`LRX_POS_DE_SEL +: 2];
  assign i_source_select = misc_control[`LRX_POS_I_SEL +: 2];
  assign q_source_select = misc_control[`LRX_POS_Q_SEL +: 2];
  assign cdi_mode = misc_control[`LRX_POS_MODE +: 2];

  // substituted word for one path; shared by i and q
  function automatic logic [WIDTH-1:0] pick(input logic [1:0] sel, input logic de,
    input logic [WIDTH-1:0] data, input logic [WIDTH-1:0] level);
    case (sel)
      lrx_pkg::LRX_SRC_PASS: pick = data;
      lrx_pkg::LRX_SRC_GATED: pick = de ? data : level;
      default: pick = level;
    endcase
  endfunction

  always_comb
  begin
    case (de_select)
      2'h0: data_enable = align_a; // [RQ15]
      2'h1: data_enable = align_b; // [RQ15]
      2'h2: data_enable = 1'b0; // [RQ15]
      default: data_enable = 1'b1; // [RQ15]
    endcase
    // unused mode code falls back to x2 so the stream never stalls
    case (cdi_mode)
      lrx_pkg::LRX_MODE_X4: ratio = `LRX_RATIO_X4; // [RQ7]
      lrx_pkg::LRX_MODE_X8: ratio = `LRX_RATIO_X8; // [RQ7]
      default: ratio = `LRX_RATIO_X2; // [RQ7]
    endcase
    next_cdi_i = cdi_i;
    next_cdi_q = cdi_q;
    next_rate_left = (rate_left != 4'h0) ? rate_left - 4'h1 : 4'h0;
    if (crossing_soft_reset)
    begin
      next_cdi_i = '0; // [RQ4]
      next_cdi_q = '0; // [RQ4]
      next_rate_left = 4'h0; // [RQ4]
    end
    else if (word_valid)
    begin
      next_cdi_i = word_i;
      next_cdi_q = word_q;
      next_rate_left = ratio; // [RQ7]
    end
    next_dsp_strobe = (rate_left != 4'h0);
    next_dsp_i = pick(i_source_select, data_enable, cdi_i, i_constant_level); // [RQ5]
    next_dsp_q = pick(q_source_select, data_enable, cdi_q, q_constant_level); // [RQ6]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cdi_i <= '0;
      cdi_q <= '0;
      rate_left <= 4'h0;
      dsp_i <= '0;
      dsp_q <= '0;
      dsp_strobe <= 1'b0;
    end
    else
    begin
      cdi_i <= next_cdi_i;
      cdi_q <= next_cdi_q;
      rate_left <= next_rate_left;
      dsp_i <= next_dsp_i;
      dsp_q <= next_dsp_q;
      dsp_strobe <= next_dsp_strobe;
    end
  end

  // ----------------------------------------
  // pin 0 observation
  // ----------------------------------------
  logic [1:0] osc_meta;
  logic [1:0] irq_meta;
  logic osc_sync;
  logic irq_sync;
  logic pin_value;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_meta <= 2'h0;
      irq_meta <= 2'h0;
      observe_pin0 <= 1'b0;
    end
    else
    begin
      osc_meta <= {osc_meta[0], slow_osc_pin};
      irq_meta <= {irq_meta[0], irq_out};
      observe_pin0 <= pin_value;
    end
  end
  assign osc_sync = osc_meta[1];
  assign irq_sync = irq_meta[1];
  lrx_observe_mux u_observe (
    .code(pin0_observe_code),
    .port_clk(port_clk_sync),
    .slow_osc(osc_sync),
    .rx_a(rx_a),
    .rx_b(rx_b),
    .irq(irq_sync),
    .pin_value(pin_value)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_misc_write(bit v);
    wr_take && hit(paddr, `LRX_IDX_MISC_CTRL) && pwdata[`LRX_BIT_SOFT_RST] == v;
  endsequence
  property p_soft_reset;
    s_misc_write(1'b1) |=> crossing_soft_reset ##1 (cdi_i == '0 && rate_left == 4'h0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied"); // [RQ4]
  property p_soft_idle;
    s_misc_write(1'b0) |=> !crossing_soft_reset;
  endproperty
  a_soft_idle: assert property (p_soft_idle) else $error("soft reset on zero write"); // [RQ4]
  property p_i_force;
    i_source_select[1] |=> dsp_i == $past(i_constant_level);
  endproperty
  a_i_force: assert property (p_i_force) else $error("i level not forced"); // [RQ5]
  property p_i_pass;
    i_source_select == 2'h0 |=> dsp_i == $past(cdi_i);
  endproperty
  a_i_pass: assert property (p_i_pass) else $error("i data not passed"); // [RQ5]
  property p_q_gated;
    q_source_select == 2'h1 && !data_enable |=> dsp_q == $past(q_constant_level);
  endproperty
  a_q_gated: assert property (p_q_gated) else $error("q level not substituted"); // [RQ6]
  property p_de_force;
    de_select == 2'h2 |-> !data_enable;
  endproperty
  a_de_force: assert property (p_de_force) else $error("data enable not forced low"); // [RQ15]
  property p_rate_x4;
    word_valid && cdi_mode == 2'h1 && !crossing_soft_reset |=> ##1 dsp_strobe[*4] ##1 !dsp_strobe;
  endproperty
  a_rate_x4: assert property (p_rate_x4) else $error("x4 ratio wrong"); // [RQ7]
  property p_level_bytes;
    wr_take && hit(paddr, `LRX_IDX_Q_LVL_HI) |=> q_constant_level[15:8] == $past(pwdata[7:0]);
  endproperty
  a_level_bytes: assert property (p_level_bytes) else $error("q high byte misplaced"); // [RQ8]
  property p_obs_and_b;
    pin0_observe_code == 10'h20F |=> observe_pin0 == $past(&rx_b);
  endproperty
  a_obs_and_b: assert property (p_obs_and_b) else $error("and of channel b wrong"); // [RQ11]
  property p_obs_bit_a;
    pin0_observe_code[9:4] == 6'h10 |=> observe_pin0 == $past(rx_a[pin0_observe_code[3:0]]);
  endproperty
  a_obs_bit_a: assert property (p_obs_bit_a) else $error("channel a bit wrong"); // [RQ10]
  property p_obs_static;
    pin0_observe_code == 10'h3FE |=> observe_pin0;
  endproperty
  a_obs_static: assert property (p_obs_static) else $error("static high missing"); // [RQ14]
  property p_obs_other;
    pin0_observe_code == 10'h155 |=> !observe_pin0;
  endproperty
  a_obs_other: assert property (p_obs_other) else $error("unlisted code not low"); // [RQ16]
  property p_irq_low;
    pin0_observe_code == 10'h3C0 |=> observe_pin0 == !$past(irq_sync);
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt polarity wrong"); // [RQ13]
endmodule
`default_nettype wire

// ---- lrx_link_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lrx_link_model (
  output logic lclk,
  output logic [15:0] da,
  output logic [15:0] db
);
  // a word then its complement per lane and frame; the clock stands low between frames
  task automatic send(input logic [15:0] a, input logic [15:0] b);
    // start off the system clock edge so no pin moves while it is sampled
    #30 da = a;
    db = b;
    #200 lclk = 1'b1;
    #300 da = ~a;
    db = ~b;
    #100 lclk = 1'b0;
    // released lanes return to the first-half words a and b until the next frame
    #300 da = a;
    db = b;
  endtask
  initial
  begin
    lclk = 1'b0;
    da = 16'h0000;
    db = 16'h0000;
  end
endmodule
`default_nettype wire

// ---- tb_lrx_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_lrx_top;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, obs, strb, err, lclk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dsp_i, dsp_q, da, db;
  int n_errors, cmp_count, cyc, nstb;
  // observe code in bits 10:1, expected pin level in bit 0
  logic [10:0] tab [14] = '{11'h000, 11'h003, 11'h201, 11'h202, 11'h21F, 11'h41F, 11'h43F, 11'h45E,
    11'h47F, 11'h781, 11'h782, 11'h7FD, 11'h7FE, 11'h2AA};
  lrx_top u_lrx_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_port_clock(lclk), .data_a_pin(da), .data_b_pin(db), .align_a_pin(1'b1), .align_b_pin(1'b0),
    .slow_osc_pin(1'b1), .irq_out(irq), .dsp_i(dsp_i), .dsp_q(dsp_q), .dsp_strobe(strb), .observe_pin0(obs));
  lrx_link_model u_lrx_link_model (.lclk(lclk), .da(da), .db(db));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    nstb += int'(strb === 1'b1);
    if (cyc == 6000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // zero or more wait states: only pready ends the access phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xfer(input logic [15:0] a, input logic [15:0] b);
    u_lrx_link_model.send(a, b);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, 12'h028 + 12'(4 * i), 32'h0);
      check("reset", rd, 32'h0);
    end
    bus(1'b0, 12'h044, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    bus(1'b1, 12'h030, 32'h34);
    bus(1'b1, 12'h034, 32'h12);
    bus(1'b1, 12'h038, 32'h78);
    bus(1'b1, 12'h03C, 32'h56);
    // falling edge: the second half of the frame is taken
    xfer(16'h7FFE, 16'h0000);
    check("dsp_i", dsp_i, 16'h8001);
    check("dsp_q", dsp_q, 16'hFFFF);
    check("ratio_x2", nstb, 32'h2);
    foreach (tab[k])
    begin
      bus(1'b1, 12'h040, {24'h0, tab[k][8:1]});
      bus(1'b1, 12'h060, {30'h0, tab[k][10:9]});
      repeat (6) @(posedge ref_clk);
      check("pin0", obs, tab[k][0]);
    end
    bus(1'b1, 12'h02C, 32'h38);
    repeat (3) @(posedge ref_clk);
    check("forced_i", dsp_i, 16'h1234);
    check("forced_q", dsp_q, 16'h5678);
    bus(1'b1, 12'h02C, 32'h14);
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, 12'h028, 32'(s << 4));
      repeat (3) @(posedge ref_clk);
      check("gated_i", dsp_i, (s == 1 || s == 2) ? 16'h1234 : 16'h8001);
      check("gated_q", dsp_q, (s == 1 || s == 2) ? 16'h5678 : 16'hFFFF);
    end
    bus(1'b1, 12'h028, 32'h5);
    bus(1'b1, 12'h02C, 32'h1);
    nstb = 0;
    xfer(16'h1234, 16'hABCD);
    check("ratio_x4", nstb, 32'h4);
    bus(1'b0, 12'h064, 32'h0);
    check("rx_a", rd[15:0], 16'hABCD);
    bus(1'b1, 12'h02C, 32'h80);
    repeat (3) @(posedge ref_clk);
    check("soft_rst", dsp_i, 16'h0);
    bus(1'b0, 12'h02C, 32'h0);
    check("misc", rd, 32'h0);
    bus(1'b1, 12'h028, 32'h3);
    bus(1'b1, 12'h02C, 32'h2);
    nstb = 0;
    xfer(16'h1111, 16'h2222);
    xfer(16'h3333, 16'h4444);
    check("il_i", dsp_i, 16'h1111);
    check("il_q", dsp_q, 16'h3333);
    check("ratio", nstb, 32'h8);
    give_verdict();
  end
endmodule
`default_nettype wire
